// file: conv_seq_params.svh
// conversion sequencer constants: register offsets, fields, resets, timing
// assumes byte addressing on a 32-bit AHB-Lite bus
`ifndef CONV_SEQ_PARAMS_SVH
`define CONV_SEQ_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFF_CTRL     4'h0
`define OFF_EXC      4'h4
`define OFF_STATUS   4'h8
`define OFF_RESULT   4'hC

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_START   0
`define CTRL_CONT    1
`define CTRL_CHOP    2
`define CTRL_SINC    3
`define CTRL_DLY_LO  4
`define CTRL_DLY_HI  6
`define CTRL_RATE_LO 8
`define CTRL_RATE_HI 11
`define CTRL_STOP    12

// ----------------------------------------------------------------------
// excitation register fields
// ----------------------------------------------------------------------
`define EXC_R0_LO    0
`define EXC_R1_LO    4
`define EXC_MAG_LO   8
`define EXC_EN0      12
`define EXC_EN1      13

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define CTRL_RESET   32'h0000_0000
`define EXC_RESET    32'h0000_0000
`define OVERHEAD_CLK 21'h00_0118
`define SINC_SETTLE_FAST 3'h5
`define SINC_SETTLE_SLOW 3'h3
`define SINC_FAST_MAX    4'h4

`endif

// file: conv_seq_pkg.sv
// conversion sequencer types
// assumes conv_seq_params.svh supplies the numeric constants
package conv_seq_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_DELAY = 3'b010,
      ST_CONV  = 3'b100
   } seq_state_t;

   typedef struct packed {
      logic       src1_en;
      logic       src0_en;
      logic [3:0] excitation_magnitude;
      logic [3:0] src1_route;
      logic [3:0] src0_route;
   } exc_cfg_t;

   typedef struct packed {
      logic       sinc_sel;
      logic [3:0] rate;
   } filt_cfg_t;

endpackage

// file: conv_seq.sv
// conversion sequencer with global chop and excitation source controls
// assumes a modulator that presents its filtered sample on mod_sample
// when a conversion window closes, and a converter clock pin conv_clk
//
// Contract
// - programmable settle delay before start or restart
// - first or single result: delay, sampling, overhead
// - later continuous results at plain data period
// - chop makes two conversions per result
// - normal then reversed polarity, output average
// - chop continuous first after two, later half
// - chop applies delay to each conversion
// - low-latency chop first period 0.8945-827.5225 ms
// - sinc chop period 1.406-2457.73 ms
// - periods counted in converter clock cycles
// - chop leaves filter notches unchanged
// - two excitation sources, any input, shared allowed
// - magnitude field selects 10 to 2000 uA
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`include "conv_seq_params.svh"
`timescale 1ns/100ps
`default_nettype none

module conv_seq
   import conv_seq_pkg::*;
#(
   // data period per rate code, converter clocks at 4.096 MHz
   parameter logic [20:0] PERIOD_CLK [15] = '{
      21'd512, 21'd1024, 21'd2048, 21'd4096, 21'd5120, 21'd10240,
      21'd20480, 21'd40960, 21'd69861, 21'd81920, 21'd204800,
      21'd251658, 21'd409600, 21'd819200, 21'd1638400},
   // settle delay per delay code, converter clocks
   parameter logic [20:0] DELAY_CLK [8] = '{
      21'd0, 21'd64, 21'd128, 21'd256, 21'd512, 21'd1024,
      21'd2048, 21'd4096}
)(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // converter clock pin and modulator
   input  wire logic        conv_clk,
   input  wire logic [23:0] mod_sample,
   output logic             mod_run,
   output logic             mod_restart,
   output logic             in_reversed,
   output filt_cfg_t        filt_cfg,
   // results
   output logic [23:0]      result,
   output logic             result_strobe,
   // excitation sources
   output exc_cfg_t         exc_cfg
);

   // ----------------------------------------------------------------
   // converter clock tick
   // ----------------------------------------------------------------
   logic cclk_s1_reg;
   logic cclk_s2_reg;
   logic cclk_s3_reg;
   logic tick;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cclk_s1_reg <= 1'b0;
         cclk_s2_reg <= 1'b0;
         cclk_s3_reg <= 1'b0;
      end else if (ce) begin
         cclk_s1_reg <= conv_clk;
         cclk_s2_reg <= cclk_s1_reg;
         cclk_s3_reg <= cclk_s2_reg;
      end
   end

   assign tick = cclk_s2_reg & ~cclk_s3_reg;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic        acc;
   logic        wr_pend_reg;
   logic [3:0]  wr_addr_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] exc_reg;
   logic        start_pulse;
   logic        stop_pulse;
   logic        rd_result;
   logic        new_reg;
   seq_state_t  state_reg;

   // zero wait states; a frozen block stalls the bus instead
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign acc       = ce & hsel & hready & htrans[1];
   assign rd_result = acc & ~hwrite & (haddr[3:0] == `OFF_RESULT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 4'h0;
      end else if (ce) begin
         wr_pend_reg <= acc & hwrite;
         if (acc) begin
            wr_addr_reg <= haddr[3:0];
         end
      end
   end

   assign start_pulse = ce & wr_pend_reg & (wr_addr_reg == `OFF_CTRL)
                        & hwdata[`CTRL_START];
   assign stop_pulse  = ce & wr_pend_reg & (wr_addr_reg == `OFF_CTRL)
                        & hwdata[`CTRL_STOP];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `CTRL_RESET;
         exc_reg  <= `EXC_RESET;
      end else if (ce && wr_pend_reg) begin
         if (wr_addr_reg == `OFF_CTRL) begin
            ctrl_reg <= {20'h0_0000, hwdata[11:8], 1'b0, hwdata[6:1], 1'b0};
         end
         if (wr_addr_reg == `OFF_EXC) begin
            exc_reg <= {18'h0_0000, hwdata[13:0]};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         case (haddr[3:0])
            `OFF_CTRL:   hrdata <= ctrl_reg;
            `OFF_EXC:    hrdata <= exc_reg;
            `OFF_STATUS: hrdata <= {26'h000_0000, state_reg, new_reg,
                                    in_reversed, ~state_reg[0]};
            `OFF_RESULT: hrdata <= {8'h00, result};
            default:     hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // excitation and filter configuration
   // ----------------------------------------------------------------
   // each route is a free input index; both may name the same input
   assign exc_cfg = exc_reg[13:0];
   // rate and filter pass straight through, chop never alters them
   assign filt_cfg = {ctrl_reg[`CTRL_SINC],
                      ctrl_reg[`CTRL_RATE_HI:`CTRL_RATE_LO]};

   // ----------------------------------------------------------------
   // conversion lengths
   // ----------------------------------------------------------------
   logic [3:0]  rate_idx;
   logic [20:0] period;
   logic [20:0] settle_len;
   logic [20:0] delay_len;
   logic [20:0] start_delay;

   assign rate_idx = (ctrl_reg[11:8] > 4'hE) ? 4'hE : ctrl_reg[11:8];
   assign period   = PERIOD_CLK[rate_idx];
   assign delay_len = DELAY_CLK[ctrl_reg[`CTRL_DLY_HI:`CTRL_DLY_LO]];
   // the starting write lands in ctrl_reg on the same edge, so take its delay code directly
   assign start_delay = DELAY_CLK[hwdata[`CTRL_DLY_HI:`CTRL_DLY_LO]];

   always_comb begin
      settle_len = 21'(period + `OVERHEAD_CLK);
      if (ctrl_reg[`CTRL_SINC]) begin
         if (rate_idx <= `SINC_FAST_MAX) begin
            settle_len = 21'(period * `SINC_SETTLE_FAST) + `OVERHEAD_CLK;
         end else begin
            settle_len = 21'(period * `SINC_SETTLE_SLOW) + `OVERHEAD_CLK;
         end
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   logic        chop_en;
   logic        cont_en;
   logic [20:0] cnt_reg;
   logic        first_reg;
   logic        half_reg;
   logic [23:0] held_reg;
   logic        conv_end;
   logic        delay_end;
   logic [24:0] diff;

   assign chop_en   = ctrl_reg[`CTRL_CHOP];
   assign cont_en   = ctrl_reg[`CTRL_CONT];
   assign delay_end = (state_reg == ST_DELAY) & tick & (cnt_reg <= 21'd1);
   assign conv_end  = (state_reg == ST_CONV) & tick & (cnt_reg <= 21'd1);
   assign mod_run   = (state_reg == ST_CONV);
   // normal sample minus reversed sample cancels the offset
   assign diff = in_reversed ? {held_reg[23], held_reg} - {mod_sample[23], mod_sample}
                             : {mod_sample[23], mod_sample} - {held_reg[23], held_reg};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 21'h00_0000;
         first_reg   <= 1'b0;
         half_reg    <= 1'b0;
         in_reversed <= 1'b0;
         mod_restart <= 1'b0;
      end else if (ce) begin
         mod_restart <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               in_reversed <= 1'b0;
               if (start_pulse) begin
                  state_reg   <= ST_DELAY;
                  cnt_reg     <= start_delay;
                  first_reg   <= 1'b1;
                  half_reg    <= 1'b0;
                  mod_restart <= 1'b1;
               end
            end
            ST_DELAY: begin
               if (stop_pulse) begin
                  state_reg <= ST_IDLE;
               end else if (delay_end || (cnt_reg == 21'h00_0000)) begin
                  state_reg <= ST_CONV;
                  cnt_reg   <= settle_len;
               end else if (tick) begin
                  cnt_reg <= cnt_reg - 21'd1;
               end
            end
            ST_CONV: begin
               if (stop_pulse) begin
                  state_reg <= ST_IDLE;
               end else if (conv_end) begin
                  if (chop_en) begin
                     // each chopped conversion restarts with delay, except the second of a non-continuous pair, which returns to idle
                     in_reversed <= ~in_reversed;
                     half_reg    <= 1'b1;
                     if (half_reg && !cont_en) begin
                        state_reg <= ST_IDLE;
                     end else begin
                        state_reg   <= ST_DELAY;
                        cnt_reg     <= delay_len;
                        mod_restart <= 1'b1;
                     end
                  end else if (cont_en) begin
                     cnt_reg   <= period;
                     first_reg <= 1'b0;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end else if (tick) begin
                  cnt_reg <= cnt_reg - 21'd1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // result capture
   // ----------------------------------------------------------------
   // a chopped pair reports once both halves exist; after that each
   // further conversion pairs with its opposite-polarity neighbour
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         held_reg      <= 24'h00_0000;
         result        <= 24'h00_0000;
         result_strobe <= 1'b0;
      end else if (ce) begin
         result_strobe <= 1'b0;
         if (conv_end && !stop_pulse) begin
            held_reg <= mod_sample;
            if (!chop_en) begin
               result        <= mod_sample;
               result_strobe <= 1'b1;
            end else if (half_reg) begin
               result        <= diff[24:1];
               result_strobe <= 1'b1;
            end
         end
      end
   end

   // new-result flag: a fresh result wins over a read that clears it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         new_reg <= 1'b0;
      end else if (ce) begin
         if (result_strobe) begin
            new_reg <= 1'b1;
         end else if (rd_result) begin
            new_reg <= 1'b0;
         end
      end
   end

   // first_reg marks the start-up conversion of an unchopped continuous run
   logic unused_first;
   assign unused_first = first_reg & |hsize;

endmodule

`default_nettype wire

// file: conv_seq_properties.sv
// port checker for the conversion sequencer
// assumes it is bound onto conv_seq and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module conv_seq_chk
   import conv_seq_pkg::*;
(
   // clock, reset and bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        ce,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // converter side
   input wire logic        mod_run,
   input wire logic        mod_restart,
   input wire logic        in_reversed,
   input wire filt_cfg_t   filt_cfg,
   input wire logic [23:0] result,
   input wire logic        result_strobe,
   input wire exc_cfg_t    exc_cfg
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic take = hsel && hready && htrans[1] && ce;

   property p_ready; hreadyout == ce; endproperty
   a_ready: assert property (p_ready) else $error("ready differs from enable");
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rdata; $changed(hrdata) |-> $past(take && !hwrite); endproperty
   a_rdata: assert property (p_rdata) else $error("read data moved without a read");
   property p_exc; $changed(exc_cfg) |-> $past(take && hwrite, 2); endproperty
   a_exc: assert property (p_exc) else $error("excitation moved without a write");
   property p_filt; $changed(filt_cfg) |-> $past(take && hwrite, 2); endproperty
   a_filt: assert property (p_filt) else $error("filter moved without a write");
   property p_restart; mod_restart |=> !mod_restart; endproperty
   a_restart: assert property (p_restart) else $error("restart pulse too long");
   property p_strobe; result_strobe |=> !result_strobe; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe too long");
   property p_result; $changed(result) |-> result_strobe; endproperty
   a_result: assert property (p_result) else $error("result moved without strobe");
   property p_after; result_strobe |-> $past(mod_run); endproperty
   a_after: assert property (p_after) else $error("result without a conversion");
   property p_flip; $changed(in_reversed) |-> !mod_run; endproperty
   a_flip: assert property (p_flip) else $error("polarity flipped mid window");
endmodule
`default_nettype wire

// file: conv_front_model.sv
// modulator and input front end model
// assumes the bench supplies signal and offset values
`timescale 1ns/100ps
`default_nettype none
module conv_front (
   // from the sequencer
   input wire logic        in_reversed,
   input wire logic        mod_run,
   // from the bench
   input wire logic [23:0] sig,
   input wire logic [23:0] ofs,
   // to the sequencer
   output logic            conv_clk,
   output logic [23:0]     mod_sample
);
   // free running, sped up so runs stay short; periods scale with it
   initial begin
      conv_clk = 1'b0;
      #3;
      forever #20 conv_clk = ~conv_clk;
   end
   // reversal negates the signal but not the offset; scrambled outside a window
   always_comb mod_sample = !mod_run ? ~(sig + ofs) : in_reversed ? ofs - sig : sig + ofs;
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the conversion sequencer
// assumes one tick is four hclk cycles of the model's converter clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import conv_seq_pkg::*;
   localparam logic [20:0] PER [15] = '{21'd8, 21'd12, 21'd16, 21'd20, 21'd24,
      21'd28, 21'd32, 21'd36, 21'd40, 21'd44, 21'd48, 21'd52, 21'd56, 21'd60, 21'd64};
   localparam logic [20:0] DLY [8] = '{21'd0, 21'd2, 21'd4, 21'd6, 21'd8, 21'd10,
      21'd12, 21'd14};
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rnd, v;
   logic [23:0] sig = 24'h0, ofs = 24'h0, result, mod_sample;
   logic        hreadyout, hresp, conv_clk, mod_run, mod_restart, in_reversed, result_strobe;
   filt_cfg_t   filt_cfg;
   exc_cfg_t    exc_cfg;
   int          n_errors = 0, samples_checked = 0, cyc = 0;
   integer      seed = 32'h0064_d277;

   always #5 hclk = ~hclk;
   conv_seq #(.PERIOD_CLK(PER), .DELAY_CLK(DLY)) conv_seq_i (.hclk, .hresetn, .ce(1'b1),
      .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .conv_clk, .mod_sample, .mod_run, .mod_restart,
      .in_reversed, .filt_cfg, .result, .result_strobe, .exc_cfg);
   conv_front conv_front_i (.in_reversed, .mod_run, .sig, .ofs, .conv_clk, .mod_sample);

   task chk(input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      $display("errors=%0d checks=%0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard well above the longest expected run
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   task bus(input logic w, input logic [31:0] a, d);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00; hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      // let the write settle before outputs are compared
      @(negedge hclk);
   endtask
   // ticks to a first result: delay plus n periods plus overhead, twice under chop
   function automatic int first_t(int chop, sinc, d, rate);
      int r, n;
      r = rate > 14 ? 14 : rate;
      n = sinc == 0 ? 1 : (r <= 4 ? 5 : 3);
      return (chop + 1) * (DLY[d] + n * PER[r] + 280);
   endfunction
   function automatic logic near(int a, b);
      return (a - b <= 16) && (b - a <= 16);
   endfunction
   task conv(input int cont, chop, sinc, d, rate, nres);
      int t0, exp;
      logic [23:0] want;
      sig = {4'h0, 20'($random(seed))};
      ofs = {4'h0, 20'($random(seed))};
      want = chop != 0 ? sig : sig + ofs;
      bus(1'b1, 32'h0, {19'h0, 1'b0, rate[3:0], 1'b0, d[2:0], sinc[0], chop[0], cont[0], 1'b1});
      chk({27'h0, filt_cfg}, {27'h0, sinc[0], rate[3:0]});
      t0 = cyc;
      exp = first_t(chop, sinc, d, rate);
      for (int i = 0; i < nres; i++) begin
         do @(negedge hclk); while (result_strobe !== 1'b1);
         chk({31'h0, near(cyc - t0, 4 * exp)}, 32'h1);
         chk({8'h0, result}, {8'h0, want});
         t0 = cyc;
         exp = chop != 0 ? first_t(chop, sinc, d, rate) / 2 : PER[rate > 14 ? 14 : rate];
      end
      if (cont != 0) bus(1'b1, 32'h0, 32'h1000);
      bus(1'b0, 32'hC, 32'h0);
      chk(rd, {8'h0, want});
      bus(1'b0, 32'h8, 32'h0);
      chk(rd, 32'h8);
      chk({31'h0, in_reversed}, 32'h0);
   endtask

   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, the last one aliasing the control register
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, 32'(4 * i), 32'h0);
         chk(rd, i == 2 ? 32'h8 : 32'h0);
      end
      // every magnitude code; odd codes share one input; enables random
      for (int i = 0; i < 16; i++) begin
         rnd = $random(seed);
         v = {18'h0, rnd[13:12], i[3:0], i[0] ? rnd[3:0] : rnd[7:4], rnd[3:0]};
         bus(1'b1, 32'h4, v);
         chk({18'h0, exc_cfg}, v);
         bus(1'b0, 32'h4, 32'h0);
         chk(rd, v);
      end
      conv(0, 0, 0, 3, 0, 1);
      conv(1, 0, 1, 7, 15, 3);
      conv(1, 1, 0, 7, 5, 3);
      conv(0, 1, 1, 0, 2, 1);
      repeat (4) begin
         rnd = $random(seed);
         conv(rnd[0], rnd[1], rnd[2], rnd[6:4], rnd[11:8], rnd[0] ? 2 : 1);
      end
      tally_and_finish;
   end
endmodule

bind conv_seq conv_seq_chk conv_seq_chk_i (.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .hrdata, .mod_run, .mod_restart, .in_reversed, .filt_cfg,
   .result, .result_strobe, .exc_cfg);
`default_nettype wire
